/* File: logic/enc_counter_pkg.sv */
// Constants for the incremental encoder counter channel.
// Assumes one 50 MHz device clock; shared by the counter core and its top.
package enc_counter_pkg;
  // ----------------------------------------------------------------
  // Feature configuration bit positions
  // ----------------------------------------------------------------
  localparam int CFG_COUNTER_MODE = 15;
  localparam int CFG_FULL_IMAGE   = 6;
  localparam int CFG_LOCK_HIGH    = 5;
  localparam int CFG_LOCK_LOW     = 4;
  localparam logic [15:0] CFG_RESET_FULL    = 16'h0040;
  localparam logic [15:0] CFG_RESET_COMPACT = 16'h0000;

  // ----------------------------------------------------------------
  // Control byte bit positions
  // ----------------------------------------------------------------
  localparam int CB_ARM_ZERO    = 0;
  localparam int CB_DATA_SRC    = 1;
  localparam int CB_PRESET      = 2;
  localparam int CB_ARM_RISE    = 3;
  localparam int CB_ARM_FALL    = 4;
  localparam int CB_CLEAR_LATCH = 5;
  localparam int CB_REG_COMM    = 7;

  // ----------------------------------------------------------------
  // Status byte bit positions
  // ----------------------------------------------------------------
  localparam int SB_ZERO_VALID = 0;
  localparam int SB_DATA_SRC   = 1;
  localparam int SB_PRESET_ACK = 2;
  localparam int SB_ZERO_LEVEL = 3;
  localparam int SB_GATE_LEVEL = 4;
  localparam int SB_REG_COMM   = 7;

  localparam int COUNT_W = 32;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 32'h0000_0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE  = 32'h0000_0001;
  localparam int IMAGE_BYTES = 5;
endpackage

/* File: logic/pin_sync.sv */
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes inputs come from outside the i_ref_clk domain.
`timescale 1ns/100ps
module pin_sync
  import enc_counter_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // First stage feeds only the second
  always_comb begin
    state_next.meta = i_async;
    state_next.sync = state_reg.meta;
  end

  // State register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_sync = state_reg.sync;
endmodule

/* File: logic/incremental_encoder_counter.sv */
// Incremental encoder up/down counter channel with gate lock, latch
// capture (full variant only) and preset, exchanged with a controller through a process image.
// Assumes the image bytes come from clocked coupler logic on i_ref_clk,
// and encoder pins are asynchronous.
`timescale 1ns/100ps
module incremental_encoder_counter
  import enc_counter_pkg::*;
#(
  parameter bit REDUCED_VARIANT = 1'b0
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  input  wire logic               i_enc_a,
  input  wire logic               i_enc_b,
  input  wire logic               i_enc_c,
  input  wire logic               i_latch_gate,
  input  wire logic               i_second_channel_a_input,
  input  wire logic [15:0]        i_feature_config_reg,
  input  wire logic               i_feature_config_we,
  input  wire logic               i_coupler_compact,
  input  wire logic [7:0]         i_control_byte_one,
  input  wire logic [COUNT_W-1:0] i_preset_value_word,
  output logic      [7:0]         o_status_byte_one,
  output logic      [COUNT_W-1:0] o_input_data_word,
  output logic                    o_full_image,
  output logic      [15:0]        o_feature_config
);
  typedef struct packed {
    logic [15:0]        cfg;
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] latch;
    logic               a_prev;
    logic               latch_prev;
    logic               c_prev;
    logic               preset_prev;
    logic               preset_ack;
    logic               zero_valid;
    logic               rise_done;
    logic               fall_done;
    logic [7:0]         status;
    logic [COUNT_W-1:0] data_word;
  } enc_state_t;

  enc_state_t state_reg;
  enc_state_t state_next;
  logic [4:0] pins_sync;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH (5)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   ({i_second_channel_a_input, i_latch_gate, i_enc_c, i_enc_b, i_enc_a}),
    .o_sync    (pins_sync)
  );

  logic a_s;
  logic b_s;
  logic c_s;
  logic latch_s;
  logic a2_s;
  assign a_s     = pins_sync[0];
  assign b_s     = pins_sync[1];
  assign c_s     = pins_sync[2];
  assign latch_s = pins_sync[3];
  assign a2_s    = pins_sync[4];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic       proc_mode;
    logic       gate_lvl;
    logic       locked;
    logic       count_en;
    logic       rise_edge;
    logic       fall_edge;
    logic       c_rise;
    logic       preset_rise;
    logic       clear_hit;
    logic [7:0] cb;
    proc_mode   = 1'b0;
    gate_lvl    = 1'b0;
    locked      = 1'b0;
    count_en    = 1'b0;
    rise_edge   = 1'b0;
    fall_edge   = 1'b0;
    c_rise      = 1'b0;
    preset_rise = 1'b0;
    clear_hit   = 1'b0;
    cb          = i_control_byte_one;
    state_next  = state_reg;

    if (i_feature_config_we) begin
      state_next.cfg = i_feature_config_reg;
    end

    proc_mode = ~cb[CB_REG_COMM];
    if (!proc_mode) begin
      cb = 8'h00;
    end
    if (REDUCED_VARIANT) begin
      cb[CB_CLEAR_LATCH] = 1'b0;
      cb[CB_ARM_FALL]    = 1'b0;
      cb[CB_ARM_RISE]    = 1'b0;
      cb[CB_ARM_ZERO]    = 1'b0;
    end

    // Edge detection on synchronised pins and the preset bit
    state_next.a_prev      = a_s;
    state_next.latch_prev  = latch_s;
    state_next.c_prev      = c_s;
    state_next.preset_prev = cb[CB_PRESET];
    rise_edge   = latch_s & ~state_reg.latch_prev;
    fall_edge   = ~latch_s & state_reg.latch_prev;
    c_rise      = c_s & ~state_reg.c_prev;
    preset_rise = cb[CB_PRESET] & ~state_reg.preset_prev;

    gate_lvl = REDUCED_VARIANT ? a2_s : latch_s;
    locked = (state_reg.cfg[CFG_LOCK_HIGH] & gate_lvl) |
             (state_reg.cfg[CFG_LOCK_LOW] & ~gate_lvl);
    if (REDUCED_VARIANT && !a2_s) begin
      locked = 1'b1;
    end

    count_en = state_reg.cfg[CFG_COUNTER_MODE] & ~locked & a_s & ~state_reg.a_prev;
    if (count_en) begin
      state_next.count = b_s ? state_reg.count + COUNT_ONE : state_reg.count - COUNT_ONE;
    end

    if (cb[CB_ARM_RISE] && rise_edge && !state_reg.rise_done) begin
      state_next.latch     = state_reg.count;
      state_next.rise_done = 1'b1;
    end else if (cb[CB_ARM_FALL] && !cb[CB_ARM_RISE] && fall_edge && !state_reg.fall_done) begin
      state_next.latch     = state_reg.count;
      state_next.fall_done = 1'b1;
    end else if (cb[CB_ARM_ZERO] && c_rise && !state_reg.zero_valid) begin
      state_next.latch      = state_reg.count;
      state_next.zero_valid = 1'b1;
    end
    // Disarm re-enables the next first edge
    if (!cb[CB_ARM_RISE]) begin
      state_next.rise_done = 1'b0;
    end
    if (!cb[CB_ARM_FALL]) begin
      state_next.fall_done = 1'b0;
    end
    if (!cb[CB_ARM_ZERO]) begin
      state_next.zero_valid = 1'b0;
    end

    clear_hit = cb[CB_CLEAR_LATCH] &
                ((cb[CB_ARM_RISE] & rise_edge) | (~cb[CB_ARM_RISE] & cb[CB_ARM_FALL] & fall_edge));
    if (clear_hit) begin
      state_next.count = COUNT_ZERO;
    end

    if (preset_rise) begin
      state_next.count      = i_preset_value_word;
      state_next.preset_ack = 1'b1;
    end else if (!cb[CB_PRESET]) begin
      state_next.preset_ack = 1'b0;
    end

    state_next.data_word = cb[CB_DATA_SRC] ? state_next.latch : state_next.count;

    state_next.status                = 8'h00;
    state_next.status[SB_REG_COMM]   = ~proc_mode;
    state_next.status[SB_DATA_SRC]   = cb[CB_DATA_SRC];
    state_next.status[SB_PRESET_ACK] = state_next.preset_ack;
    state_next.status[SB_ZERO_VALID] = state_next.zero_valid;
    if (!REDUCED_VARIANT) begin
      state_next.status[SB_GATE_LEVEL] = latch_s;
      state_next.status[SB_ZERO_LEVEL] = c_s;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // variant default image
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg     <= '0;
      state_reg.cfg <= REDUCED_VARIANT ? CFG_RESET_COMPACT : CFG_RESET_FULL;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // status byte plus word
  assign o_status_byte_one = state_reg.status;
  assign o_input_data_word = state_reg.data_word;
  assign o_full_image      = REDUCED_VARIANT ?
                             (state_reg.cfg[CFG_FULL_IMAGE] & ~i_coupler_compact) : 1'b1;
  assign o_feature_config  = state_reg.cfg;
endmodule

/* File: verif/enc_counter_checker.sv */
// Port assertions for the encoder counter channel.
// Assumes bind into the top; one clock, async high reset.
`timescale 1ns/100ps
module enc_counter_checker
  import enc_counter_pkg::*;
#(
  parameter bit REDUCED_VARIANT = 1'b0
) (
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic [7:0]  i_control_byte_one,
  input wire logic [31:0] i_preset_value_word,
  input wire logic [15:0] i_feature_config_reg,
  input wire logic        i_feature_config_we,
  input wire logic        i_coupler_compact,
  input wire logic [7:0]  o_status_byte_one,
  input wire logic [31:0] o_input_data_word,
  input wire logic        o_full_image,
  input wire logic [15:0] o_feature_config
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  wire logic [7:0]  cb = i_control_byte_one;
  wire logic [7:0]  sb = o_status_byte_one;
  wire logic [15:0] fc = o_feature_config;
  default clocking dc @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  AST_PRESET_LOAD: assert property ($rose(cb[CB_PRESET]) && !cb[CB_REG_COMM] && !cb[CB_DATA_SRC]
    |=> o_input_data_word == $past(i_preset_value_word) && sb[SB_PRESET_ACK]) else $error("preset not taken");
  AST_ACK_CLEAR: assert property (!cb[CB_PRESET] && !cb[CB_REG_COMM] |=> !sb[SB_PRESET_ACK])
    else $error("preset ack stuck");
  AST_SRC_MIRROR: assert property (!cb[CB_REG_COMM] |=> sb[SB_DATA_SRC] == $past(cb[CB_DATA_SRC]))
    else $error("source bit wrong");
  AST_REG_COMM: assert property (cb[CB_REG_COMM] |=> sb[SB_REG_COMM]) else $error("mode bit wrong");
  AST_CFG_WRITE: assert property (i_feature_config_we |=> fc == $past(i_feature_config_reg))
    else $error("config not written");
  AST_FULL_IMAGE: assert property (o_full_image ==
    (REDUCED_VARIANT ? (fc[CFG_FULL_IMAGE] & !i_coupler_compact) : 1'b1))
    else $error("image size wrong");
  AST_IDLE_HOLD: assert property (!fc[CFG_COUNTER_MODE] && cb == 8'h00 && $stable(cb)
    |=> $stable(o_input_data_word)) else $error("count moved outside mode");
  AST_GATE_LOCK: assert property (!REDUCED_VARIANT && fc[CFG_COUNTER_MODE] && fc[CFG_LOCK_HIGH]
    && $stable(fc) && sb[SB_GATE_LEVEL] && $past(sb[SB_GATE_LEVEL]) && cb == 8'h00 && $stable(cb)
    |=> !sb[SB_GATE_LEVEL] || $stable(o_input_data_word)) else $error("locked count moved");
endmodule
bind incremental_encoder_counter enc_counter_checker #(.REDUCED_VARIANT(REDUCED_VARIANT)) i_chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_control_byte_one(i_control_byte_one),
  .i_preset_value_word(i_preset_value_word), .i_feature_config_reg(i_feature_config_reg),
  .i_feature_config_we(i_feature_config_we), .i_coupler_compact(i_coupler_compact),
  .o_status_byte_one(o_status_byte_one),
  .o_input_data_word(o_input_data_word), .o_full_image(o_full_image), .o_feature_config(o_feature_config));

/* File: verif/ctrl_model.sv */
// Controller model: registers the control byte the bench asks for.
// Assumes bench drives i_want on the device clock.
`timescale 1ns/100ps
module ctrl_model #(
  parameter bit REDUCED_VARIANT = 1'b0
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_want,
  output logic      [7:0] o_cb
);
  // ----------------------------------------
  // Control byte
  // ----------------------------------------
  // Legal control byte, one edge late
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cb <= 8'h00;
    end else begin
      o_cb <= i_want & (REDUCED_VARIANT ? 8'hc6 : (i_want[0] ? 8'he7 : 8'hff));
    end
  end
endmodule

/* File: verif/incremental_encoder_counter_tb.sv */
// Bench for the encoder counter channel, full and reduced variants.
// Assumes the controller model drives the control byte.
`timescale 1ns/100ps
module incremental_encoder_counter_tb;
  import enc_counter_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  pin = 4'h0;
  logic [15:0] cfg = 16'h0000;
  logic        we = 1'b0;
  logic [7:0]  want = 8'h00;
  logic [31:0] pre = 32'h0;
  logic [7:0]  cb, sb;
  logic [31:0] dw;
  logic [15:0] fc;
  logic        full;
  logic        a2 = 1'b0;
  logic [7:0]  cb_r, sb_r;
  logic [31:0] dw_r;
  logic [15:0] fc_r;
  logic        full_r;
  int          n_mismatch = 0;
  int          compares = 0;
  // ----------------------------------------
  // Clock, model, device
  // ----------------------------------------
  always #10 clk = ~clk;
  ctrl_model i_ctrl (.i_ref_clk(clk), .i_rst(rst), .i_want(want), .o_cb(cb));
  incremental_encoder_counter i_dut (.i_ref_clk(clk), .i_rst(rst), .i_enc_a(pin[0]), .i_enc_b(pin[1]),
    .i_enc_c(pin[2]), .i_latch_gate(pin[3]), .i_second_channel_a_input(1'b0), .i_feature_config_reg(cfg),
    .i_feature_config_we(we), .i_coupler_compact(1'b1), .i_control_byte_one(cb), .i_preset_value_word(pre),
    .o_status_byte_one(sb), .o_input_data_word(dw), .o_full_image(full), .o_feature_config(fc));
  // Reduced variant: second A input gates the counter
  ctrl_model #(.REDUCED_VARIANT(1'b1)) i_ctrl_r (.i_ref_clk(clk), .i_rst(rst), .i_want(want), .o_cb(cb_r));
  incremental_encoder_counter #(.REDUCED_VARIANT(1'b1)) i_dut_r (.i_ref_clk(clk), .i_rst(rst), .i_enc_a(pin[0]),
    .i_enc_b(pin[1]), .i_enc_c(pin[2]), .i_latch_gate(pin[3]), .i_second_channel_a_input(a2),
    .i_feature_config_reg(cfg), .i_feature_config_we(we), .i_coupler_compact(1'b0), .i_control_byte_one(cb_r),
    .i_preset_value_word(pre), .o_status_byte_one(sb_r), .o_input_data_word(dw_r), .o_full_image(full_r),
    .o_feature_config(fc_r));
  // Helper tasks
  task tk(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task lv(int k, logic v);
    @(posedge clk) pin[k] <= v;
    tk(5);
  endtask
  task pl(int k);
    lv(k, 1'b1);
    lv(k, 1'b0);
  endtask
  task ctl(logic [7:0] v);
    @(posedge clk) want <= v;
    tk(3);
  endtask
  task wcfg(logic [15:0] v);
    @(posedge clk) begin
      cfg <= v;
      we <= 1'b1;
    end
    @(posedge clk) we <= 1'b0;
    tk(2);
  endtask
  task close_out;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    tk(2);
    chk(fc, 32'h0040);
    chk(full, 32'h1);
    chk(fc_r, 32'h0);
    chk(full_r, 32'h0);
    @(posedge clk) pre <= 32'hffff_fffe;
    ctl(8'h04);
    chk(dw, 32'hffff_fffe);
    chk(sb[2], 32'h1);
    ctl(8'h00);
    chk(sb[2], 32'h0);
    pl(0);
    chk(dw, 32'hffff_fffe);
    wcfg(16'h8040);
    chk(full_r, 32'h1);
    lv(1, 1'b1);
    repeat (3) pl(0);
    chk(dw, 32'h1);
    chk(dw_r, 32'hffff_fffe);
    @(posedge clk) a2 <= 1'b1;
    lv(1, 1'b0);
    repeat (2) pl(0);
    chk(dw, 32'hffff_ffff);
    chk(dw_r, 32'hffff_fffc);
    @(posedge clk) a2 <= 1'b0;
    wcfg(16'h8060);
    lv(3, 1'b1);
    chk(sb[4], 32'h1);
    pl(0);
    chk(dw, 32'hffff_ffff);
    lv(3, 1'b0);
    wcfg(16'h8050);
    pl(0);
    chk(dw, 32'hffff_ffff);
    wcfg(16'h8040);
    pl(0);
    ctl(8'h08);
    pl(3);
    pl(0);
    pl(3);
    ctl(8'h0a);
    chk(dw, 32'hffff_fffe);
    chk(sb[1], 32'h1);
    ctl(8'h00);
    chk(dw, 32'hffff_fffd);
    ctl(8'h01);
    pl(2);
    chk(sb[0], 32'h1);
    ctl(8'h03);
    chk(dw, 32'hffff_fffd);
    ctl(8'h00);
    chk(sb[0], 32'h0);
    ctl(8'h10);
    lv(3, 1'b1);
    pl(0);
    lv(3, 1'b0);
    pl(0);
    pl(3);
    ctl(8'h12);
    chk(dw, 32'hffff_fffc);
    ctl(8'h00);
    ctl(8'h18);
    lv(3, 1'b1);
    pl(0);
    lv(3, 1'b0);
    ctl(8'h1a);
    chk(dw, 32'hffff_fffb);
    ctl(8'h28);
    pl(3);
    chk(dw, 32'h0);
    @(posedge clk) pre <= 32'h1234_5678;
    ctl(8'h80);
    ctl(8'h84);
    chk(sb[7], 32'h1);
    chk(dw, 32'h0);
    chk(dw_r, 32'hffff_fffc);
    close_out();
  end
endmodule
